// >>> core/sadc_params.svh
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_FRAME_CLOCKS 16
`define SADC_AZ_CLOCKS 3
`define SADC_RES_BITS 12
`define SADC_CLK_MHZ 100
`define SADC_POR_TIME_US 2500
`define SADC_POR_CYCLES (`SADC_POR_TIME_US * `SADC_CLK_MHZ)
`define SADC_CNT_W 5
`endif

// >>> core/sadc_pkg.sv
`default_nettype none
package sadc_pkg;
  typedef enum logic [3:0] {
    SADC_POR = 4'b0001,
    SADC_TRACK = 4'b0010,
    SADC_CONV = 4'b0100,
    SADC_TAIL = 4'b1000
  } sadc_state_t;
  typedef struct packed {
    logic dataOut;
    logic dataOeN;
  } sadc_pin_t;
  typedef struct packed {
    logic compPowered;
    logic arrayHold;
    logic autoZero;
  } sadc_analog_t;
endpackage : sadc_pkg
`default_nettype wire

// >>> core/sadc_serial_readout.sv
// What this block and its host do
// R1: Chip select high keeps comparator off and array tracking.
// R2: Chip select falling edge freezes the array and starts a frame.
// R3: Host supplies sixteen serial clocks per full frame.
// R4: First three clocks power up and auto-zero the comparator.
// R5: One clock per result bit, twelve or ten bits.
// R6: Each decision appears on the output one clock after it is made.
// R7: On clock fifteen comparator powers down and array tracks again.
// R8: Final decision is driven during the sixteenth clock.
// R9: After last bit output is zero until chip select rises, then released.
// R10: Output changes on serial clock falling edges.
// R11: Host samples data on serial clock rising edges.
// R12: Host runs serial clock between 10 kHz and 18 MHz.
// R13: Internal reset about 2.5 ms after power; no conversion before.
// R14: Host performs one dummy conversion after reset and discards it.
// R15: Dummy frame is about 1 us at 18 MHz.
// R16: Host allows at least 200 ns of tracking before next frame.
// R17: Early chip select rise gives reduced resolution and early low power.
// R18: Results are two's complement, sign bit set for negative values.
// R19: Result bits leave most significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
module sadc_serial_readout
  import sadc_pkg::*;
#(
  parameter int RES_BITS = `SADC_RES_BITS,
  parameter int POR_CYCLES = `SADC_POR_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins from host
  input wire logic chipSelectN,
  input wire logic serial_clock_pin,
  // Comparator decision from analog core
  input wire logic compDecision,
  // Serial data pin
  output logic serial_result_out,
  output logic serialOeN,
  // Analog core control
  output sadc_analog_t analogCtl,
  output logic porDone,
  // Completed result word
  output logic [RES_BITS-1:0] resultWord,
  output logic resultValid,
  input wire logic resultReady
);
  localparam int CNT_W = `SADC_CNT_W;
  localparam logic [CNT_W-1:0] AZ_END = CNT_W'(`SADC_AZ_CLOCKS);
  localparam logic [CNT_W-1:0] DEC_END = CNT_W'(`SADC_AZ_CLOCKS + RES_BITS);
  localparam logic [CNT_W-1:0] FRAME_END = CNT_W'(`SADC_FRAME_CLOCKS);

  // Two-stage synchronisers
  logic [1:0] csSync_q, sckSync_q;
  logic csPrev_q, sckPrev_q;
  // Reset to the idle-high level of both pins so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      csSync_q <= 2'h3;
      sckSync_q <= 2'h3;
      csPrev_q <= 1'h1;
      sckPrev_q <= 1'h1;
    end else begin
      csSync_q <= {csSync_q[0], chipSelectN};
      sckSync_q <= {sckSync_q[0], serial_clock_pin};
      csPrev_q <= csSync_q[1];
      sckPrev_q <= sckSync_q[1];
    end
  end
  wire csLow = ~csSync_q[1];
  wire csFall = csPrev_q & ~csSync_q[1];
  wire sckFall = sckPrev_q & ~sckSync_q[1];

  // Power-on reset timer; long count kept as parameter for simulation
  logic [31:0] porCnt_q;
  wire porEnd = (porCnt_q == 32'(POR_CYCLES - 1));

  sadc_state_t state_q, state_d;
  logic [CNT_W-1:0] clkCnt_q, clkCnt_d;
  logic [RES_BITS-1:0] sar_q, sar_d;
  logic pendBit_q, pendBit_d;
  sadc_pin_t pin_q, pin_d;
  logic push_d;

  // Falling-edge count within the frame; decisions occupy clocks 4..15
  wire inDecide = (clkCnt_q >= AZ_END) && (clkCnt_q < DEC_END); // [R5]
  wire lastDecision = (clkCnt_q == DEC_END - 1'b1);
  // With RES_BITS of 10 the final bit leaves on clock 14 instead
  wire [CNT_W-1:0] clkCntInc = clkCnt_q + 1'b1;

  // Frame sequencer
  always_comb begin
    state_d = state_q;
    clkCnt_d = clkCnt_q;
    sar_d = sar_q;
    pendBit_d = pendBit_q;
    pin_d = pin_q;
    push_d = 1'b0;
    case (state_q)
      SADC_POR: begin
        if (porEnd) state_d = SADC_TRACK; // [R13]
      end
      SADC_TRACK: begin
        pin_d = '{dataOut: 1'b0, dataOeN: 1'b1}; // [R9]
        if (csFall) begin // [R2]
          state_d = SADC_CONV;
          clkCnt_d = '0;
          pin_d = '{dataOut: 1'b0, dataOeN: 1'b0};
        end
      end
      SADC_CONV: begin
        if (!csLow) begin // [R17]
          state_d = SADC_TRACK;
          pin_d.dataOeN = 1'b1;
        end else if (sckFall) begin // [R10]
          clkCnt_d = clkCntInc;
          // Previous decision driven now, one clock late
          pin_d.dataOut = (clkCnt_q > AZ_END) ? pendBit_q : 1'b0; // [R6]
          if (inDecide) begin
            pendBit_d = compDecision;
            sar_d = {sar_q[RES_BITS-2:0], compDecision}; // [R19] [R18]
          end
          if (lastDecision) begin // [R7]
            state_d = SADC_TAIL;
            push_d = 1'b1;
          end
        end
      end
      SADC_TAIL: begin
        if (!csLow) begin
          state_d = SADC_TRACK;
          pin_d.dataOeN = 1'b1; // [R9]
        end else if (sckFall) begin
          if (clkCnt_q < FRAME_END) clkCnt_d = clkCntInc;
          // Final bit on the next clock, then zeros
          pin_d.dataOut = (clkCnt_q == DEC_END) ? pendBit_q : 1'b0; // [R8] [R9]
        end
      end
      default: state_d = SADC_POR;
    endcase
  end

  // Comparator power and array hold follow state only; auto-zero also uses the clock count
  wire convPhase = (state_q == SADC_CONV);
  wire azPhase = convPhase && (clkCnt_q < AZ_END); // [R4]
  sadc_analog_t analog_d;
  assign analog_d = '{compPowered: convPhase, arrayHold: convPhase, autoZero: azPhase}; // [R1] [R7]

  // Two-entry buffer for result words
  localparam int BCNT_W = $clog2(BUF_DEPTH) + 1;
  logic [RES_BITS-1:0] bufMem_q [BUF_DEPTH];
  logic [BCNT_W-1:0] bufCnt_q;
  logic bufRd_q, bufWr_q;
  wire bufFull = (bufCnt_q == BCNT_W'(BUF_DEPTH));
  wire bufEmpty = (bufCnt_q == '0);
  // A word arriving while full is dropped; the host clock cannot be stalled
  wire doPush = push_d & ~bufFull;
  wire doPop = resultValid & resultReady;
  // Pointers wrap by toggling, which ties the buffer to two entries
  wire bufRdNext = doPop ? ~bufRd_q : bufRd_q;
  wire bufPopLast = doPop && (bufCnt_q == BCNT_W'(1));
  wire [BCNT_W-1:0] bufCntNext = bufCnt_q + BCNT_W'(doPush) - BCNT_W'(doPop);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= SADC_POR;
      porCnt_q <= 32'h0;
      clkCnt_q <= '0;
      sar_q <= '0;
      pendBit_q <= 1'b0;
      pin_q <= '{dataOut: 1'b0, dataOeN: 1'b1};
      analogCtl <= '0;
      porDone <= 1'b0;
    end else begin
      state_q <= state_d;
      if (!porEnd && state_q == SADC_POR) porCnt_q <= porCnt_q + 32'h1;
      clkCnt_q <= clkCnt_d;
      sar_q <= sar_d;
      pendBit_q <= pendBit_d;
      pin_q <= pin_d;
      analogCtl <= analog_d;
      porDone <= (state_d != SADC_POR);
    end
  end
  assign serial_result_out = pin_q.dataOut;
  assign serialOeN = pin_q.dataOeN;

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : gBuf
      always_ff @(posedge sys_clk) begin
        if (!rst_n) bufMem_q[gi] <= '0;
        else if (doPush && bufWr_q == 1'(gi)) bufMem_q[gi] <= sar_d;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bufCnt_q <= '0;
      bufRd_q <= 1'b0;
      bufWr_q <= 1'b0;
    end else begin
      if (doPush) bufWr_q <= ~bufWr_q;
      bufRd_q <= bufRdNext;
      bufCnt_q <= bufCntNext;
    end
  end

  // Word and valid registered so the consumer sees flop outputs only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resultValid <= 1'b0;
      resultWord <= '0;
    end else begin
      resultValid <= !bufEmpty && !bufPopLast;
      resultWord <= bufMem_q[bufRdNext];
    end
  end
endmodule : sadc_serial_readout
`default_nettype wire

// >>> verification/sadc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
  // Clock
  input wire logic sys_clk,
  // Host pins
  output logic chipSelectN = 1'b1,
  output logic serial_clock_pin = 1'b1,
  input wire logic dataWire,
  // Falls so far in the frame
  output int falls = 0
);
  // Clock stays high outside frames; 16 sys_clk per period keeps the sync margin
  task automatic run_frame(input int n, output logic [15:0] got);
    got = 16'h0000;
    @(posedge sys_clk) chipSelectN <= 1'b0;
    for (int i = 1; i <= n; i++) begin
      repeat (8) @(posedge sys_clk);
      serial_clock_pin <= 1'b0;
      falls <= i;
      repeat (8) @(posedge sys_clk);
      serial_clock_pin <= 1'b1;
      got = {got[14:0], dataWire};
    end
    repeat (8) @(posedge sys_clk);
    chipSelectN <= 1'b1;
    falls <= 0;
    repeat (30) @(posedge sys_clk);
  endtask : run_frame
endmodule : sadc_host
`default_nettype wire

// >>> verification/sadc_serial_readout_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_sva
  import sadc_pkg::*;
(
  // Clock, reset, host pins
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chipSelectN,
  input wire logic serial_clock_pin,
  // Device outputs
  input wire logic serial_result_out,
  input wire logic serialOeN,
  input wire sadc_analog_t analogCtl,
  input wire logic porDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Covers the pin sync plus the output register
  sequence cs_idle;
    chipSelectN [*8];
  endsequence
  idle_dark_a: assert property (cs_idle |-> !analogCtl.compPowered && !analogCtl.arrayHold)
    else $error("awake while idle");
  oe_release_a: assert property (cs_idle |-> serialOeN)
    else $error("pin not released");
  por_gate_a: assert property (!porDone |-> serialOeN && !analogCtl.arrayHold)
    else $error("frame before power up");
  hold_start_a: assert property ($fell(chipSelectN) && porDone |-> ##[2:6] analogCtl.arrayHold)
    else $error("no hold");
  wake_zero_a: assert property ($rose(analogCtl.compPowered) |-> analogCtl.autoZero)
    else $error("no autozero");
  zero_quiet_a: assert property (analogCtl.autoZero && !serialOeN |-> !serial_result_out)
    else $error("data in autozero");
  track_back_a: assert property ($fell(analogCtl.compPowered) |-> ##[0:2] !analogCtl.arrayHold)
    else $error("array still held");
  fall_edge_a: assert property ($changed(serial_result_out) && !chipSelectN && !serialOeN |-> !serial_clock_pin)
    else $error("data moved on rise");
  track_on_fall_a: assert property ($fell(analogCtl.arrayHold) && !chipSelectN |-> !serial_clock_pin)
    else $error("track resumed off a fall");
endmodule : sadc_sva
bind sadc_serial_readout sadc_sva chk (.*);
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic resultReady = 1'b0;
  logic [15:0] codeX = 16'h0000;
  logic [15:0] got;
  logic [11:0] resultWord;
  logic serial_result_out, serialOeN, porDone, resultValid;
  wire logic chipSelectN, serial_clock_pin;
  int falls;
  int mismatches = 0;
  int n_compared = 0;
  // Comparator answers the bit decided at the current fall
  wire logic compDecision = falls < 16 && codeX[15 - falls];
  wire logic dataWire = serialOeN ? 1'bz : serial_result_out;
  always #5 sys_clk = ~sys_clk;
  sadc_serial_readout #(.POR_CYCLES(20)) dut (.sys_clk, .rst_n, .chipSelectN, .serial_clock_pin, .compDecision,
    .serial_result_out, .serialOeN, .analogCtl(), .porDone, .resultWord, .resultValid, .resultReady);
  sadc_host host (.sys_clk, .chipSelectN, .serial_clock_pin, .dataWire, .falls);
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic pop(input logic [11:0] exp);
    @(posedge sys_clk);
    check("word", {4'h0, exp}, {4'h0, resultWord});
    check("valid", 16'h0001, {15'h0, resultValid});
    resultReady <= 1'b1;
    @(posedge sys_clk) resultReady <= 1'b0;
  endtask : pop
  task automatic t_code(input logic [11:0] c);
    codeX <= {4'h0, c};
    host.run_frame(17, got);
    check("serial", {3'h0, c, 1'b0}, got);
    pop(c);
  endtask : t_code
  task automatic t_short;
    codeX <= 16'h0C3A;
    host.run_frame(8, got);
    check("short", 16'h000C, got);
    check("noword", 16'h0000, {15'h0, resultValid});
  endtask : t_short
  // Third word meets a full buffer and is lost
  task automatic t_buffer;
    for (int i = 1; i <= 3; i++) begin
      codeX <= {4'h0, i[3:0], 8'h00};
      host.run_frame(16, got);
    end
    pop(12'h100);
    pop(12'h200);
    @(posedge sys_clk);
    check("empty", 16'h0000, {15'h0, resultValid});
  endtask : t_buffer
  // Power-on wait, then the dummy frame whose word is thrown away
  task automatic t_power;
    check("porlow", 16'h0000, {15'h0, porDone});
    for (int i = 0; i < 100 && porDone !== 1'b1; i++) @(posedge sys_clk);
    check("por", 16'h0001, {15'h0, porDone});
    host.run_frame(16, got);
    check("dummy", 16'h0001, {15'h0, resultValid});
    resultReady <= 1'b1;
    repeat (2) @(posedge sys_clk);
    resultReady <= 1'b0;
  endtask : t_power
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_power;
    t_code(12'h800);
    t_code(12'h7FF);
    t_code(12'h000);
    t_short;
    t_buffer;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    wrap_up;
  end
endmodule : tb
`default_nettype wire
